/* include/mcss_pkg.sv */
// Package for the core clock source select block: register map, field layout,
// source codes and switchover counts.
// Assumes a 32-bit APB register bus and a 25 MHz system clock.
package mcss_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CSEL_IDX = 8'hA5;
   localparam logic [11:0] CSEL_ADDR = {2'h0, CSEL_IDX, 2'h0};
   localparam logic [7:0] CSEL_RESET = 8'h40;
   localparam int ADDR_W = 12;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_SLEEP = 7;
   localparam int BIT_RING_OSC_ENABLE = 6;
   localparam int BIT_SRC_SEL = 5;
   localparam int BIT_RATE_HI = 4;
   localparam int BIT_RATE_LO = 3;
   localparam int BIT_STABLE = 2;

   // ****************************************
   // Clock sources
   // ****************************************
   localparam int NUM_SRC = 5;
   localparam logic [2:0] SRC_RATE_3M75 = 3'h0;
   localparam logic [2:0] SRC_RATE_7M5 = 3'h1;
   localparam logic [2:0] SRC_RATE_15M = 3'h2;
   localparam logic [2:0] SRC_RATE_30M = 3'h3;
   localparam logic [2:0] SRC_RING = 3'h4;

   // Edges of the old clock, then of the new one, per changeover
   localparam logic [1:0] SWITCH_EDGES = 2'h3;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic sleep;
      logic ring_osc_enable;
      logic src_sel;
      logic [1:0] rate;
   } mcss_ctrl_t;

   typedef struct packed {
      logic ring_osc_run;
      logic osc_stop;
   } mcss_osc_t;

endpackage

/* hdl/mcss_clk_mux.sv */
// Glitch-free core clock multiplexer working on sampled clock levels.
// Assumes its source levels are already synchronised to clk_i.
`timescale 1ns/10ps
`default_nettype none

module mcss_clk_mux
   import mcss_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Sources and selection
   input wire logic [NUM_SRC-1:0] src_lvl_i,
   input wire logic [2:0] want_i,
   // Outputs
   output logic clk_o,
   output logic [2:0] cur_o,
   output logic busy_o
);

   typedef enum logic [1:0] {
      MUX_RUN = 2'b00,
      MUX_DRAIN = 2'b01,
      MUX_FILL = 2'b10
   } mcss_mux_st_t;

   mcss_mux_st_t st_q, st_d;
   logic [2:0] cur_q, cur_d;
   logic [1:0] cnt_q, cnt_d;
   logic [NUM_SRC-1:0] prev_q;
   logic out_en;
   logic cur_fall;
   logic clk_d;

   function automatic logic fall_at(input logic [NUM_SRC-1:0] p, input logic [NUM_SRC-1:0] n,
                                    input logic [2:0] s);
      fall_at = p[s] & ~n[s];
   endfunction

   assign cur_fall = fall_at(prev_q, src_lvl_i, cur_q);
   assign out_en = (st_q == MUX_RUN);
   assign clk_d = src_lvl_i[cur_q] & out_en & prev_q[cur_q];

   always_comb
   begin
      st_d = st_q;
      cur_d = cur_q;
      cnt_d = cnt_q;
      unique case (st_q)
         MUX_RUN:
         begin
            if ((want_i != cur_q) && !clk_d)
            begin
               st_d = MUX_DRAIN;
               cnt_d = 2'h0;
            end
         end
         MUX_DRAIN:
         begin
            if (cur_fall)
            begin
               cnt_d = cnt_q + 2'h1;
               if (cnt_q + 2'h1 == SWITCH_EDGES)
               begin
                  st_d = MUX_FILL;
                  cur_d = want_i;
                  cnt_d = 2'h0;
               end
            end
         end
         MUX_FILL:
         begin
            if (cur_fall)
            begin
               cnt_d = cnt_q + 2'h1;
               if (cnt_q + 2'h1 == SWITCH_EDGES)
               begin
                  st_d = MUX_RUN;
                  cnt_d = 2'h0;
               end
            end
         end
         default:
         begin
            st_d = MUX_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q <= MUX_RUN;
         cur_q <= SRC_RING;
         cnt_q <= 2'h0;
         prev_q <= '0;
         clk_o <= 1'b0;
         cur_o <= SRC_RING;
         busy_o <= 1'b0;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         cur_q <= cur_d;
         cnt_q <= cnt_d;
         prev_q <= src_lvl_i;
         clk_o <= clk_d;
         cur_o <= cur_d;
         busy_o <= (st_d != MUX_RUN);
      end
   end

endmodule
`default_nettype wire

/* hdl/mcss_top.sv */
// Core clock source select: APB register, oscillator control, power-down
// sequence and glitch-free core clock selection.
// Assumes clock sources, the PHY clock-valid level and nothing else arrive
// asynchronously; the power-down request comes from the core on clk_i.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module mcss_top
   import mcss_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Core power-down request
   input wire logic core_pd_i,
   // Asynchronous sources
   input wire logic phy_clk_valid_i,
   input wire logic [NUM_SRC-1:0] src_clk_i,
   // Oscillator control and core clock
   output logic ring_osc_run_o,
   output logic osc_stop_o,
   output logic core_clk_o,
   output logic [2:0] core_src_o,
   output logic switch_busy_o
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [NUM_SRC-1:0] src_s1_q, src_s2_q;
   logic valid_s1_q, valid_s2_q;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         src_s1_q <= '0;
         src_s2_q <= '0;
         valid_s1_q <= 1'b0;
         valid_s2_q <= 1'b0;
      end
      else if (ce_i)
      begin
         src_s1_q <= src_clk_i;
         src_s2_q <= src_s1_q;
         valid_s1_q <= phy_clk_valid_i;
         valid_s2_q <= valid_s1_q;
      end
   end

   // ****************************************
   // APB decode
   // ****************************************
   mcss_ctrl_t ctrl_q, ctrl_d;
   logic setup_ph;
   logic hit;
   logic wr_en;
   logic [7:0] reg_rd;
   logic [31:0] rdata_d;

   assign setup_ph = psel_i & ~penable_i;
   assign hit = (paddr_i == CSEL_ADDR);
   assign wr_en = psel_i & penable_i & pready_o & pwrite_i & hit & pstrb_i[0];

   assign reg_rd = {ctrl_q.sleep, ctrl_q.ring_osc_enable, ctrl_q.src_sel, ctrl_q.rate,
                    valid_s2_q, 2'h0};
   assign rdata_d = (hit & ~pwrite_i) ? {24'h0, reg_rd} : 32'h0;

   assign ctrl_d.sleep = pwdata_i[BIT_SLEEP];
   assign ctrl_d.ring_osc_enable = pwdata_i[BIT_RING_OSC_ENABLE];
   assign ctrl_d.src_sel = pwdata_i[BIT_SRC_SEL];
   assign ctrl_d.rate = pwdata_i[BIT_RATE_HI:BIT_RATE_LO];

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= mcss_ctrl_t'(CSEL_RESET[BIT_SLEEP:BIT_RATE_LO]);
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wr_en)
         begin
            ctrl_q <= ctrl_d;
         end
         pready_o <= setup_ph;
         if (setup_ph)
         begin
            prdata_o <= rdata_d;
            pslverr_o <= ~hit;
         end
      end
   end

   // ****************************************
   // Power-down sequence
   // ****************************************
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_GATE = 2'b01,
      PWR_OFF = 2'b10
   } mcss_pwr_st_t;

   mcss_pwr_st_t pwr_q, pwr_d;
   mcss_osc_t osc_d;

   always_comb
   begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PWR_RUN:
         begin
            if (core_pd_i & ctrl_q.sleep)
            begin
               pwr_d = PWR_GATE;
            end
         end
         PWR_GATE:
         begin
            pwr_d = PWR_OFF;
         end
         PWR_OFF:
         begin
            if (~core_pd_i)
            begin
               pwr_d = PWR_RUN;
            end
         end
         default:
         begin
            pwr_d = PWR_RUN;
         end
      endcase
   end

   assign osc_d.ring_osc_run = ctrl_q.ring_osc_enable & (pwr_d == PWR_RUN);
   assign osc_d.osc_stop = (pwr_d == PWR_OFF);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pwr_q <= PWR_RUN;
         ring_osc_run_o <= CSEL_RESET[BIT_RING_OSC_ENABLE];
         osc_stop_o <= 1'b0;
      end
      else if (ce_i)
      begin
         pwr_q <= pwr_d;
         ring_osc_run_o <= osc_d.ring_osc_run;
         osc_stop_o <= osc_d.osc_stop;
      end
   end

   // ****************************************
   // Core clock selection
   // ****************************************
   logic [2:0] want_src;

   assign want_src = ctrl_q.src_sel ? {1'b0, ctrl_q.rate} : SRC_RING;

   mcss_clk_mux u_mux (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .src_lvl_i(src_s2_q),
      .want_i(want_src),
      .clk_o(core_clk_o),
      .cur_o(core_src_o),
      .busy_o(switch_busy_o)
   );

endmodule
`default_nettype wire

/* sim/mcss_chk.sv */
// Checker for the core clock select block ports.
// Assumes ce_i stays high and one register at CSEL_ADDR.
`timescale 1ns/10ps
`default_nettype none

module mcss_chk
   import mcss_pkg::*;
(
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic core_pd_i,
   input wire logic phy_clk_valid_i,
   input wire logic ring_osc_run_o,
   input wire logic osc_stop_o,
   input wire logic core_clk_o,
   input wire logic [2:0] core_src_o,
   input wire logic switch_busy_o
);
   // ****************************************
   // Register shadow
   // ****************************************
   logic [7:0] sh_q;
   logic acc;
   logic [2:0] want;
   assign acc = psel_i && penable_i && pready_o && paddr_i == CSEL_ADDR;
   assign want = sh_q[5] ? {1'h0, sh_q[4:3]} : SRC_RING;
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         sh_q <= CSEL_RESET;
      else if (acc && pwrite_i && pstrb_i[0])
         sh_q <= pwdata_i[7:0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_PD_RING: assert property (core_pd_i && sh_q[7] |=> !ring_osc_run_o)
      else $error("ring oscillator on in power-down");
   AST_PD_STOP: assert property (core_pd_i && sh_q[7] ##1 core_pd_i |=> osc_stop_o)
      else $error("oscillators not stopped");
   AST_RING_OFF: assert property (!sh_q[6] |=> !ring_osc_run_o)
      else $error("ring oscillator runs while disabled");
   // Changeover waits out the high phase of the old clock first
   AST_SW_START: assert property (!switch_busy_o && core_src_o != want |-> ##[1:20] switch_busy_o)
      else $error("changeover not started");
   AST_SW_DONE: assert property ($fell(switch_busy_o) |-> core_src_o == want)
      else $error("wrong core clock source");
   AST_SW_TIME: assert property ($rose(switch_busy_o) |-> ##[1:300] !switch_busy_o)
      else $error("changeover too long");
   AST_NO_GLITCH: assert property (switch_busy_o |-> !core_clk_o)
      else $error("core clock not held during changeover");
   AST_FLAG: assert property (acc && !pwrite_i |-> prdata_o[2] == $past(phy_clk_valid_i, 3))
      else $error("stable flag wrong");
endmodule

bind mcss_top mcss_chk i_chk (.*);

`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the core clock select block.
// Assumes source clocks scaled down so the sampled mux sees each edge.
`timescale 1ns/10ps
`default_nettype none

module tb;
   import mcss_pkg::*;
   typedef struct packed {logic [7:0] wv; logic phy; logic [2:0] src;} mcss_row_t;
   logic clk_i, rst_i, psel_i, penable_i, pwrite_i, core_pd_i, phy_clk_valid_i;
   logic [ADDR_W-1:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0] pstrb_i;
   logic pready_o, pslverr_o, ring_osc_run_o, osc_stop_o, core_clk_o, switch_busy_o, er;
   logic [2:0] core_src_o;
   logic [NUM_SRC-1:0] src_clk_i;
   int error_cnt, comparisons, polls;
   mcss_row_t rows [6] = '{'{8'h60, 1'h1, 3'h0}, '{8'h68, 1'h0, 3'h1}, '{8'h70, 1'h1, 3'h2},
      '{8'h78, 1'h0, 3'h3}, '{8'h5B, 1'h1, 3'h4}, '{8'h44, 1'h0, 3'h4}};

   mcss_top i_dut (.ce_i(1'h1), .*);

   initial
   begin
      clk_i = 1'h0;
      forever #20 clk_i = ~clk_i;
   end
   initial src_clk_i = '0;
   // Sources toggle on falling clock edges only
   always #640 src_clk_i[0] = ~src_clk_i[0];
   always #320 src_clk_i[1] = ~src_clk_i[1];
   always #160 src_clk_i[2] = ~src_clk_i[2];
   always #80 src_clk_i[3] = ~src_clk_i[3];
   // Ring runs only while the block enables it
   always #120 if (ring_osc_run_o) src_clk_i[4] = ~src_clk_i[4];

   // ****************************************
   // Tasks
   // ****************************************
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic stop_bad;
      error_cnt++;
      report_and_stop();
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge clk_i);
      penable_i <= 1'h1;
      @(posedge clk_i);
      while (!pready_o && n < 50)
      begin
         @(posedge clk_i);
         n++;
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
      if (n == 50)
         stop_bad();
   endtask
   task automatic wsw;
      int n;
      n = 0;
      // Changeover starts once the old clock is low
      repeat (24) @(negedge clk_i);
      while (switch_busy_o && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 400)
         stop_bad();
   endtask

   initial
   begin
      rst_i = 1'h1;
      psel_i = 1'h0;
      penable_i = 1'h0;
      pwrite_i = 1'h0;
      paddr_i = '0;
      pwdata_i = '0;
      pstrb_i = 4'hF;
      core_pd_i = 1'h0;
      phy_clk_valid_i = 1'h0;
      error_cnt = 0;
      comparisons = 0;
      polls = 0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      apb(1'h0, CSEL_ADDR, 32'h0, 4'hF);
      chk("reset", 32'h40, rd);
      chk("src", 32'h4, 32'(core_src_o));
      for (int i = 0; i < 6; i++)
      begin
         phy_clk_valid_i <= rows[i].phy;
         apb(1'h1, CSEL_ADDR, {24'h0, rows[i].wv}, 4'hF);
         wsw();
         apb(1'h0, CSEL_ADDR, 32'h0, 4'hF);
         chk("read", {24'h0, rows[i].wv[7:3], rows[i].phy, 2'h0}, rd);
         chk("src", 32'(rows[i].src), 32'(core_src_o));
      end
      apb(1'h0, CSEL_ADDR + 12'h4, 32'h0, 4'hF);
      chk("unmapped", 32'h80000000, {er, rd[30:0]});
      apb(1'h1, CSEL_ADDR, 32'hF8, 4'h0);
      apb(1'h0, CSEL_ADDR, 32'h0, 4'hF);
      chk("strobe", 32'h40, rd);
      apb(1'h1, CSEL_ADDR, 32'h78, 4'hF);
      wsw();
      chk("fast", 32'h3, 32'(core_src_o));
      apb(1'h1, CSEL_ADDR, 32'h38, 4'hF);
      wsw();
      chk("ringoff", 32'h0, 32'(ring_osc_run_o));
      apb(1'h1, CSEL_ADDR, 32'h78, 4'hF);
      core_pd_i <= 1'h1;
      repeat (3) @(negedge clk_i);
      chk("nosleep", 32'h1, {osc_stop_o, 30'h0, ring_osc_run_o});
      apb(1'h1, CSEL_ADDR, 32'hF8, 4'hF);
      repeat (3) @(negedge clk_i);
      chk("sleep", 32'h80000000, {osc_stop_o, 30'h0, ring_osc_run_o});
      @(posedge clk_i);
      core_pd_i <= 1'h0;
      repeat (2) @(negedge clk_i);
      chk("wake", 32'h1, {osc_stop_o, 30'h0, ring_osc_run_o});
      @(posedge clk_i);
      rst_i <= 1'h1;
      @(negedge clk_i);
      chk("rstsrc", 32'h4, 32'(core_src_o));
      @(posedge clk_i);
      rst_i <= 1'h0;
      apb(1'h0, CSEL_ADDR, 32'h0, 4'hF);
      chk("rstread", 32'h40, rd);
      // Clock restart: wait, then poll the stable flag
      phy_clk_valid_i <= 1'h0;
      repeat (1250) @(posedge clk_i);
      phy_clk_valid_i <= 1'h1;
      rd = 32'h0;
      while (!rd[2] && polls < 8)
      begin
         apb(1'h0, CSEL_ADDR, 32'h0, 4'hF);
         polls++;
      end
      chk("settled", 32'h44, rd);
      report_and_stop();
   end
endmodule

`default_nettype wire
